/* hdl/mip_prioritizer.sv */
// interrupt prioritizer: source flags, pin gating, fixed polling within two priority levels, vector to core, APB registers
// assumes APB master on mclk, event inputs as one-cycle pulses, core acks the index it took
//
// The APB slave port and the placing of the registers were left to the implementer.
module mip_prioritizer
	import mip_pkg::*;
(
	// clock and reset
	input wire logic mclk,
	input wire logic rst_b,
	// apb slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [MIP_AW-1:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// peripheral events
	input wire logic power_monitor_request,
	input wire logic clock_calendar_request,
	input wire logic [23:0] energy_dsp_request,
	input wire logic watchdog_overflow_request,
	input wire logic temperature_adc_request,
	input wire logic ext_irq_pin_a,
	input wire logic ext_irq_pin_b,
	input wire logic timer0_overflow_flag,
	input wire logic timer1_overflow_flag,
	input wire logic serial_bus_request,
	input wire logic transmit_done_flag,
	input wire logic receive_done_flag,
	input wire logic timer2_overflow_flag,
	input wire logic timer2_external_flag,
	// core side
	output logic int_valid,
	output logic [15:0] int_vector,
	output logic [3:0] int_index,
	input wire logic int_ack,
	input wire logic [3:0] int_ack_index,
	// interrupt line
	output logic irq
);
	logic wr_cycle, rd_cycle, hit;
	logic [7:0] wb;
	logic [7:0] timer_control_reg, serial_control_reg, timer2_control_reg;
	logic [7:0] power_monitor_flag_reg, energy_status_low, energy_status_mid, energy_status_high;
	logic [11:0] latch_q, ack_vec, req, pend, cand;
	logic [1:0] istat_q;
	logic [7:0] tc_set, tc_clr, sc_set, t2_set, pm_set;
	logic [11:0] lat_set;
	logic [1:0] is_set;
	logic pin0_gate_bit, pin1_gate_bit, ext0_level, ext1_level, fall_a, fall_b;
	// plain registers
	logic [7:0] irq_pin_config_reg, irq_pin_config_next;
	logic [11:0] enable_reg, enable_next, level_reg, level_next;
	logic [1:0] imask_reg, imask_next;
	logic pin_a_reg, pin_a_next, pin_b_reg, pin_b_next;
	// selection state
	logic sel_valid_reg, sel_valid_next;
	logic [3:0] sel_index_reg, sel_index_next;
	logic [15:0] vector_reg, vector_next;
	logic [11:0] cand_reg;

	assign wr_cycle = psel & penable & pwrite;
	assign rd_cycle = psel & penable & ~pwrite;
	assign wb = pwdata[7:0];
	assign pready = 1'b1;
	assign ack_vec = int_ack ? (12'h001 << int_ack_index) : MIP_RST_SRC;

	always_comb
	begin
		case (paddr)
			MIP_OFS_TIMER_CTRL, MIP_OFS_SERIAL_CTRL, MIP_OFS_TIMER2_CTRL, MIP_OFS_PIN_CFG,
			MIP_OFS_PWR_FLAG, MIP_OFS_ESTAT_LOW, MIP_OFS_ESTAT_MID, MIP_OFS_ESTAT_HIGH,
			MIP_OFS_ENABLE, MIP_OFS_LEVEL, MIP_OFS_VECTOR, MIP_OFS_ISTAT, MIP_OFS_IMASK: hit = 1'b1;
			default: hit = 1'b0;
		endcase
	end
	assign pslverr = psel & penable & ~hit;

	assign pin0_gate_bit = irq_pin_config_reg[MIP_PC_PIN0_GATE];
	assign pin1_gate_bit = irq_pin_config_reg[MIP_PC_PIN1_GATE];
	assign fall_a = pin_a_reg & ~ext_irq_pin_a;
	assign fall_b = pin_b_reg & ~ext_irq_pin_b;
	assign ext0_level = pin0_gate_bit & ~ext_irq_pin_a;
	assign ext1_level = pin1_gate_bit & ~ext_irq_pin_b;

	always_comb
	begin
		tc_set = MIP_RST_BYTE;
		tc_clr = MIP_RST_BYTE;
		tc_set[MIP_TC_EXT0_FLAG] = timer_control_reg[MIP_TC_EXT0_MODE] ? (fall_a & pin0_gate_bit) : ext0_level;
		tc_set[MIP_TC_EXT1_FLAG] = timer_control_reg[MIP_TC_EXT1_MODE] ? (fall_b & pin1_gate_bit) : ext1_level;
		tc_set[MIP_TC_TMR0_FLAG] = timer0_overflow_flag;
		tc_set[MIP_TC_TMR1_FLAG] = timer1_overflow_flag;
		tc_clr[MIP_TC_EXT0_FLAG] = timer_control_reg[MIP_TC_EXT0_MODE] ? ack_vec[MIP_SRC_EXT0] : 1'b1;
		tc_clr[MIP_TC_EXT1_FLAG] = timer_control_reg[MIP_TC_EXT1_MODE] ? ack_vec[MIP_SRC_EXT1] : 1'b1;
		tc_clr[MIP_TC_TMR0_FLAG] = ack_vec[MIP_SRC_TMR0];
		tc_clr[MIP_TC_TMR1_FLAG] = ack_vec[MIP_SRC_TMR1];
		sc_set = MIP_RST_BYTE;
		sc_set[MIP_SC_RX_FLAG] = receive_done_flag;
		sc_set[MIP_SC_TX_FLAG] = transmit_done_flag;
		t2_set = MIP_RST_BYTE;
		t2_set[MIP_T2_OVF_FLAG] = timer2_overflow_flag;
		t2_set[MIP_T2_EXT_FLAG] = timer2_external_flag;
		pm_set = MIP_RST_BYTE;
		pm_set[MIP_PM_FLAG] = power_monitor_request;
		lat_set = MIP_RST_SRC;
		lat_set[MIP_SRC_RTC] = clock_calendar_request;
		lat_set[MIP_SRC_WDT] = watchdog_overflow_request;
		lat_set[MIP_SRC_TEMP] = temperature_adc_request;
		lat_set[MIP_SRC_SBUS] = serial_bus_request;
		is_set = MIP_RST_IS;
		is_set[MIP_IS_ACK] = int_ack;
		is_set[MIP_IS_BLOCKED] = (fall_a & ~pin0_gate_bit) | (fall_b & ~pin1_gate_bit);
	end

	mip_flag #(.WIDTH(8)) u_timer_control_reg (.mclk(mclk), .rst_b(rst_b),
		.wr_en(wr_cycle && paddr == MIP_OFS_TIMER_CTRL), .wr_data(wb),
		.hw_set(tc_set), .hw_clr(tc_clr), .flag_q(timer_control_reg));
	mip_flag #(.WIDTH(8)) u_serial_control_reg (.mclk(mclk), .rst_b(rst_b),
		.wr_en(wr_cycle && paddr == MIP_OFS_SERIAL_CTRL), .wr_data(wb),
		.hw_set(sc_set), .hw_clr(MIP_RST_BYTE), .flag_q(serial_control_reg));
	mip_flag #(.WIDTH(8)) u_timer2_control_reg (.mclk(mclk), .rst_b(rst_b),
		.wr_en(wr_cycle && paddr == MIP_OFS_TIMER2_CTRL), .wr_data(wb),
		.hw_set(t2_set), .hw_clr(MIP_RST_BYTE), .flag_q(timer2_control_reg));
	mip_flag #(.WIDTH(8)) u_psmf (.mclk(mclk), .rst_b(rst_b),
		.wr_en(wr_cycle && paddr == MIP_OFS_PWR_FLAG), .wr_data(wb),
		.hw_set(pm_set), .hw_clr(MIP_RST_BYTE), .flag_q(power_monitor_flag_reg));
	mip_flag #(.WIDTH(8)) u_estl (.mclk(mclk), .rst_b(rst_b),
		.wr_en(wr_cycle && paddr == MIP_OFS_ESTAT_LOW), .wr_data(energy_status_low & wb),
		.hw_set(energy_dsp_request[7:0]), .hw_clr(MIP_RST_BYTE), .flag_q(energy_status_low));
	mip_flag #(.WIDTH(8)) u_estm (.mclk(mclk), .rst_b(rst_b),
		.wr_en(wr_cycle && paddr == MIP_OFS_ESTAT_MID), .wr_data(energy_status_mid & wb),
		.hw_set(energy_dsp_request[15:8]), .hw_clr(MIP_RST_BYTE), .flag_q(energy_status_mid));
	mip_flag #(.WIDTH(8)) u_esth (.mclk(mclk), .rst_b(rst_b),
		.wr_en(wr_cycle && paddr == MIP_OFS_ESTAT_HIGH), .wr_data(energy_status_high & wb),
		.hw_set(energy_dsp_request[23:16]), .hw_clr(MIP_RST_BYTE), .flag_q(energy_status_high));
	// hidden pending latches, cleared only by ack
	mip_flag #(.WIDTH(12)) u_latch (.mclk(mclk), .rst_b(rst_b),
		.wr_en(1'b0), .wr_data(MIP_RST_SRC),
		.hw_set(lat_set), .hw_clr(ack_vec), .flag_q(latch_q));
	mip_flag #(.WIDTH(2)) u_istat (.mclk(mclk), .rst_b(rst_b),
		.wr_en(wr_cycle && paddr == MIP_OFS_ISTAT), .wr_data(istat_q & ~pwdata[1:0]),
		.hw_set(is_set), .hw_clr(MIP_RST_IS), .flag_q(istat_q));
	assign irq = |(istat_q & imask_reg);

	always_comb
	begin
		req = MIP_RST_SRC;
		req[MIP_SRC_PWR] = power_monitor_flag_reg[MIP_PM_FLAG];
		req[MIP_SRC_RTC] = latch_q[MIP_SRC_RTC];
		req[MIP_SRC_DSP] = |{energy_status_high, energy_status_mid, energy_status_low};
		req[MIP_SRC_WDT] = latch_q[MIP_SRC_WDT];
		req[MIP_SRC_TEMP] = latch_q[MIP_SRC_TEMP];
		req[MIP_SRC_EXT0] = timer_control_reg[MIP_TC_EXT0_FLAG];
		req[MIP_SRC_TMR0] = timer_control_reg[MIP_TC_TMR0_FLAG];
		req[MIP_SRC_EXT1] = timer_control_reg[MIP_TC_EXT1_FLAG];
		req[MIP_SRC_TMR1] = timer_control_reg[MIP_TC_TMR1_FLAG];
		req[MIP_SRC_SBUS] = latch_q[MIP_SRC_SBUS];
		req[MIP_SRC_UART] = serial_control_reg[MIP_SC_TX_FLAG] | serial_control_reg[MIP_SC_RX_FLAG];
		req[MIP_SRC_TMR2] = timer2_control_reg[MIP_T2_OVF_FLAG] | timer2_control_reg[MIP_T2_EXT_FLAG];
	end
	assign pend = req & enable_reg;
	assign cand = (|(pend & level_reg)) ? (pend & level_reg) : pend;

	always_comb
	begin
		sel_valid_next = |cand;
		sel_index_next = MIP_SRC_PWR;
		for (int i = MIP_NSRC - 1; i >= 0; i--)
		begin
			if (cand[i])
				sel_index_next = 4'(i);
		end
		vector_next = sel_valid_next ? MIP_VECTOR_TABLE[sel_index_next] : MIP_RST_VEC;
	end

	always_ff @(posedge mclk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			sel_valid_reg <= 1'b0;
			sel_index_reg <= MIP_SRC_PWR;
			vector_reg <= MIP_RST_VEC;
			cand_reg <= MIP_RST_SRC;
		end
		else
		begin
			sel_valid_reg <= sel_valid_next;
			sel_index_reg <= sel_index_next;
			vector_reg <= vector_next;
			cand_reg <= cand;
		end
	end
	assign int_valid = sel_valid_reg;
	assign int_index = sel_index_reg;
	assign int_vector = vector_reg;

	always_comb
	begin
		irq_pin_config_next = irq_pin_config_reg;
		enable_next = enable_reg;
		level_next = level_reg;
		imask_next = imask_reg;
		pin_a_next = ext_irq_pin_a;
		pin_b_next = ext_irq_pin_b;
		if (wr_cycle)
		begin
			case (paddr)
				MIP_OFS_PIN_CFG: irq_pin_config_next = wb;
				MIP_OFS_ENABLE: enable_next = pwdata[11:0];
				MIP_OFS_LEVEL: level_next = pwdata[11:0];
				MIP_OFS_IMASK: imask_next = pwdata[1:0];
				default: ;
			endcase
		end
	end

	always_ff @(posedge mclk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			irq_pin_config_reg <= MIP_RST_BYTE;
			enable_reg <= MIP_RST_SRC;
			level_reg <= MIP_RST_SRC;
			imask_reg <= MIP_RST_IS;
			pin_a_reg <= 1'b1;
			pin_b_reg <= 1'b1;
		end
		else
		begin
			irq_pin_config_reg <= irq_pin_config_next;
			enable_reg <= enable_next;
			level_reg <= level_next;
			imask_reg <= imask_next;
			pin_a_reg <= pin_a_next;
			pin_b_reg <= pin_b_next;
		end
	end

	always_comb
	begin
		prdata = 32'h0000_0000;
		if (rd_cycle)
		begin
			case (paddr)
				MIP_OFS_TIMER_CTRL: prdata[7:0] = timer_control_reg;
				MIP_OFS_SERIAL_CTRL: prdata[7:0] = serial_control_reg;
				MIP_OFS_TIMER2_CTRL: prdata[7:0] = timer2_control_reg;
				MIP_OFS_PIN_CFG: prdata[7:0] = irq_pin_config_reg;
				MIP_OFS_PWR_FLAG: prdata[7:0] = power_monitor_flag_reg;
				MIP_OFS_ESTAT_LOW: prdata[7:0] = energy_status_low;
				MIP_OFS_ESTAT_MID: prdata[7:0] = energy_status_mid;
				MIP_OFS_ESTAT_HIGH: prdata[7:0] = energy_status_high;
				MIP_OFS_ENABLE: prdata[11:0] = enable_reg;
				MIP_OFS_LEVEL: prdata[11:0] = level_reg;
				MIP_OFS_VECTOR:
				begin
					prdata[15:0] = vector_reg;
					prdata[MIP_VR_INDEX_LSB +: 4] = sel_index_reg;
					prdata[MIP_VR_VALID] = sel_valid_reg;
				end
				MIP_OFS_ISTAT: prdata[1:0] = istat_q;
				MIP_OFS_IMASK: prdata[1:0] = imask_reg;
				default: ;
			endcase
		end
	end

	default clocking cb @(posedge mclk); endclocking
	default disable iff (!rst_b);

	chk_poll_lowest_first: assert property (sel_valid_reg |->
		((cand_reg & ((12'h001 << sel_index_reg) - 12'h001)) == MIP_RST_SRC) && cand_reg[sel_index_reg])
		else $error("selected source is not the lowest pending position");
	chk_power_wins: assert property (cand[MIP_SRC_PWR] |=> sel_valid_reg && sel_index_reg == MIP_SRC_PWR)
		else $error("power monitor request did not win");
	chk_ext0_before_timer0: assert property (cand[MIP_SRC_EXT0] |=> sel_index_reg <= MIP_SRC_EXT0)
		else $error("pin0 request lost to a later position");
	chk_timer2_last: assert property (cand[MIP_SRC_TMR2] && |cand[10:0] |=> sel_index_reg != MIP_SRC_TMR2)
		else $error("timer 2 request beat an earlier position");
	chk_timer0_flag_set: assert property (timer0_overflow_flag |=> timer_control_reg[MIP_TC_TMR0_FLAG])
		else $error("timer 0 event did not set its flag");
	chk_pin0_gated: assert property ($rose(timer_control_reg[MIP_TC_EXT0_FLAG]) &&
		!$past(wr_cycle && paddr == MIP_OFS_TIMER_CTRL) |-> $past(pin0_gate_bit))
		else $error("pin 0 flag rose while gate closed");
	chk_pin1_gated: assert property ($rose(timer_control_reg[MIP_TC_EXT1_FLAG]) &&
		!$past(wr_cycle && paddr == MIP_OFS_TIMER_CTRL) |-> $past(pin1_gate_bit))
		else $error("pin 1 flag rose while gate closed");
	chk_timer2_request: assert property (timer2_external_flag |=> req[MIP_SRC_TMR2])
		else $error("timer 2 external event raised no request");
	chk_serial_request: assert property (transmit_done_flag |=> req[MIP_SRC_UART])
		else $error("transmit event raised no serial request");
	chk_dsp_flag: assert property (energy_dsp_request[MIP_ES_DSP_FLAG] |=> energy_status_low[MIP_ES_DSP_FLAG]
		&& req[MIP_SRC_DSP]) else $error("dsp event not flagged");
	chk_select_latency: assert property (|pend |=> sel_valid_reg ##0 int_vector == MIP_VECTOR_TABLE[int_index])
		else $error("pending request not presented with its vector");
	chk_power_flag_holds: assert property (power_monitor_flag_reg[MIP_PM_FLAG] &&
		!(wr_cycle && paddr == MIP_OFS_PWR_FLAG) |=> power_monitor_flag_reg[MIP_PM_FLAG])
		else $error("power monitor flag dropped without a write");
endmodule

/* inc/mip_pkg.sv */
// package of the interrupt prioritizer: register map, field positions, sources, vectors
// assumes a 32-bit APB master and a core that acknowledges the vector it takes
package mip_pkg;
	localparam int MIP_NSRC = 12;
	localparam int MIP_AW = 8;
	// register byte offsets
	localparam logic [7:0] MIP_OFS_TIMER_CTRL = 8'h00;
	localparam logic [7:0] MIP_OFS_SERIAL_CTRL = 8'h04;
	localparam logic [7:0] MIP_OFS_TIMER2_CTRL = 8'h08;
	localparam logic [7:0] MIP_OFS_PIN_CFG = 8'h0C;
	localparam logic [7:0] MIP_OFS_PWR_FLAG = 8'h10;
	localparam logic [7:0] MIP_OFS_ESTAT_LOW = 8'h14;
	localparam logic [7:0] MIP_OFS_ESTAT_MID = 8'h18;
	localparam logic [7:0] MIP_OFS_ESTAT_HIGH = 8'h1C;
	localparam logic [7:0] MIP_OFS_ENABLE = 8'h20;
	localparam logic [7:0] MIP_OFS_LEVEL = 8'h24;
	localparam logic [7:0] MIP_OFS_VECTOR = 8'h28;
	localparam logic [7:0] MIP_OFS_ISTAT = 8'h2C;
	localparam logic [7:0] MIP_OFS_IMASK = 8'h30;
	// timer control fields
	localparam int MIP_TC_EXT0_MODE = 0;
	localparam int MIP_TC_EXT0_FLAG = 1;
	localparam int MIP_TC_EXT1_MODE = 2;
	localparam int MIP_TC_EXT1_FLAG = 3;
	localparam int MIP_TC_TMR0_FLAG = 5;
	localparam int MIP_TC_TMR1_FLAG = 7;
	// serial, timer 2, power monitor, energy fields
	localparam int MIP_SC_RX_FLAG = 0;
	localparam int MIP_SC_TX_FLAG = 1;
	localparam int MIP_T2_EXT_FLAG = 6;
	localparam int MIP_T2_OVF_FLAG = 7;
	localparam int MIP_PM_FLAG = 6;
	localparam int MIP_ES_DSP_FLAG = 7;
	// pin configuration fields
	localparam int MIP_PC_PIN0_GATE = 0;
	localparam int MIP_PC_PIN1_GATE = 6;
	// interrupt status fields
	localparam int MIP_IS_ACK = 0;
	localparam int MIP_IS_BLOCKED = 1;
	// vector register fields
	localparam int MIP_VR_INDEX_LSB = 16;
	localparam int MIP_VR_VALID = 31;
	// polling positions
	localparam logic [3:0] MIP_SRC_PWR = 4'h0;
	localparam logic [3:0] MIP_SRC_RTC = 4'h1;
	localparam logic [3:0] MIP_SRC_DSP = 4'h2;
	localparam logic [3:0] MIP_SRC_WDT = 4'h3;
	localparam logic [3:0] MIP_SRC_TEMP = 4'h4;
	localparam logic [3:0] MIP_SRC_EXT0 = 4'h5;
	localparam logic [3:0] MIP_SRC_TMR0 = 4'h6;
	localparam logic [3:0] MIP_SRC_EXT1 = 4'h7;
	localparam logic [3:0] MIP_SRC_TMR1 = 4'h8;
	localparam logic [3:0] MIP_SRC_SBUS = 4'h9;
	localparam logic [3:0] MIP_SRC_UART = 4'hA;
	localparam logic [3:0] MIP_SRC_TMR2 = 4'hB;
	// vector addresses by polling position
	localparam logic [15:0] MIP_VECTOR_TABLE [MIP_NSRC] = '{
		16'h0043, 16'h0053, 16'h004B, 16'h005B, 16'h0033, 16'h0003,
		16'h000B, 16'h0013, 16'h001B, 16'h003B, 16'h0023, 16'h002B};
	// reset values
	localparam logic [7:0] MIP_RST_BYTE = 8'h00;
	localparam logic [11:0] MIP_RST_SRC = 12'h000;
	localparam logic [1:0] MIP_RST_IS = 2'h0;
	localparam logic [15:0] MIP_RST_VEC = 16'h0000;
endpackage

/* hdl/mip_flag.sv */
// sticky flag group: software load, hardware clear, hardware set wins
// assumes set and clear pulses synchronous to mclk
module mip_flag
	import mip_pkg::*;
#(
	parameter int WIDTH = 8
)(
	// clock and reset
	input wire logic mclk,
	input wire logic rst_b,
	// software load
	input wire logic wr_en,
	input wire logic [WIDTH-1:0] wr_data,
	// hardware events
	input wire logic [WIDTH-1:0] hw_set,
	input wire logic [WIDTH-1:0] hw_clr,
	// flag state
	output logic [WIDTH-1:0] flag_q
);
	logic [WIDTH-1:0] flag_reg;
	logic [WIDTH-1:0] flag_next;

	always_comb
	begin
		flag_next = wr_en ? wr_data : flag_reg;
		flag_next = (flag_next & ~hw_clr) | hw_set;
	end

	always_ff @(posedge mclk or negedge rst_b)
	begin
		if (!rst_b)
			flag_reg <= '0;
		else
			flag_reg <= flag_next;
	end

	assign flag_q = flag_reg;
endmodule

/* bench/mip_core_model.sv */
// core model: takes the selected vector and acknowledges it after a delay
// assumes int_valid and int_index registered on mclk
module mip_core_model
	import mip_pkg::*;
(
	// clock and reset
	input wire logic mclk,
	input wire logic rst_b,
	// control from bench
	input wire logic ack_enable,
	input wire logic [3:0] ack_delay,
	// vector side
	input wire logic int_valid,
	input wire logic [3:0] int_index,
	output logic int_ack,
	output logic [3:0] int_ack_index,
	// last vector taken
	output logic [3:0] taken_index
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [3:0] wait_cnt;
	logic [1:0] hold_cnt;
	// ack pulse, then ignore int_valid for 3 cycles
	always_ff @(posedge mclk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			int_ack <= 1'b0;
			int_ack_index <= 4'h0;
			taken_index <= 4'h0;
			wait_cnt <= 4'h0;
			hold_cnt <= 2'h0;
		end
		else
		begin
			int_ack <= 1'b0;
			int_ack_index <= ~taken_index;
			if (hold_cnt != 2'h0)
				hold_cnt <= hold_cnt - 2'h1;
			else if (int_valid && ack_enable)
			begin
				if (wait_cnt >= ack_delay)
				begin
					int_ack <= 1'b1;
					int_ack_index <= int_index;
					taken_index <= int_index;
					wait_cnt <= 4'h0;
					hold_cnt <= 2'h3;
				end
				else
					wait_cnt <= wait_cnt + 4'h1;
			end
			else
				wait_cnt <= 4'h0;
		end
	end
endmodule

/* bench/tb_mip_prioritizer.sv */
// testbench of the interrupt prioritizer: apb master, event drivers, core model
// assumes zero-wait apb slave and registered vector outputs
module tb_mip_prioritizer
	import mip_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	logic mclk = 1'b0, rst_b = 1'b0;
	logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0, prdata, rd;
	logic pready, pslverr, rd_err;
	logic pwr = 1'b0, rtc = 1'b0, wdt = 1'b0, temp = 1'b0, pin_a = 1'b1, pin_b = 1'b1;
	logic [23:0] dsp = 24'h0;
	logic t0 = 1'b0, t1 = 1'b0, sbus = 1'b0, txd = 1'b0, rxd = 1'b0, t2o = 1'b0, t2e = 1'b0;
	logic int_valid, int_ack, irq, ack_enable = 1'b0;
	logic [15:0] int_vector;
	logic [3:0] int_index, int_ack_index, taken_index, ack_delay = 4'h2;
	int failures = 0, check_count = 0, cycles = 0;
	mip_prioritizer dut_u (.mclk(mclk), .rst_b(rst_b), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.power_monitor_request(pwr), .clock_calendar_request(rtc), .energy_dsp_request(dsp),
		.watchdog_overflow_request(wdt), .temperature_adc_request(temp), .ext_irq_pin_a(pin_a),
		.ext_irq_pin_b(pin_b), .timer0_overflow_flag(t0), .timer1_overflow_flag(t1),
		.serial_bus_request(sbus), .transmit_done_flag(txd), .receive_done_flag(rxd),
		.timer2_overflow_flag(t2o), .timer2_external_flag(t2e), .int_valid(int_valid),
		.int_vector(int_vector), .int_index(int_index), .int_ack(int_ack), .int_ack_index(int_ack_index),
		.irq(irq));
	mip_core_model core_u (.mclk(mclk), .rst_b(rst_b), .ack_enable(ack_enable), .ack_delay(ack_delay),
		.int_valid(int_valid), .int_index(int_index), .int_ack(int_ack), .int_ack_index(int_ack_index),
		.taken_index(taken_index));
	initial
	begin
		forever #50 mclk = ~mclk;
	end
	task automatic print_verdict();
		$display("checks %0d failures %0d", check_count, failures);
		if (failures == 0 && check_count > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	always @(posedge mclk)
	begin
		cycles++;
		if (cycles == 6000)
		begin
			failures++;
			print_verdict();
		end
	end
	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp)
		begin
			failures++;
			$display("mismatch %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic idle(input int n);
		repeat (n) @(posedge mclk);
	endtask
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		@(posedge mclk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge mclk);
		penable <= 1'b1;
		do @(posedge mclk); while (pready !== 1'b1);
		rd = prdata;
		rd_err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic rd_chk(input string what, input logic [7:0] a, input logic [31:0] exp);
		apb(1'b0, a, 32'h0);
		check(what, rd, exp);
	endtask
	// one-cycle pulse on every source whose polling bit is set
	task automatic fire(input logic [11:0] m);
		@(posedge mclk);
		{pwr, rtc, wdt, temp, t0, t1, sbus, txd, t2o} <= {m[0], m[1], m[3], m[4], m[6], m[8], m[9], m[10], m[11]};
		dsp <= {16'h0, m[2], 7'h0};
		pin_a <= ~m[5];
		pin_b <= ~m[7];
		@(posedge mclk);
		{pwr, rtc, wdt, temp, t0, t1, sbus, txd, t2o} <= 9'h0;
		dsp <= 24'h0;
		pin_a <= 1'b1;
		pin_b <= 1'b1;
		idle(3);
	endtask
	task automatic t_reset();
		check("irq", {31'h0, irq}, 32'h0);
		check("pready", {31'h0, pready}, 32'h1);
		rd_chk("timer ctrl", MIP_OFS_TIMER_CTRL, 32'h0);
		rd_chk("vector reg", MIP_OFS_VECTOR, 32'h0);
		rd_chk("unmapped", 8'h3C, 32'h0);
		check("slverr", {31'h0, rd_err}, 32'h1);
		$display("test reset done");
	endtask
	task automatic t_order();
		apb(1'b1, MIP_OFS_ENABLE, 32'hFFF);
		apb(1'b1, MIP_OFS_PIN_CFG, 32'h41);
		apb(1'b1, MIP_OFS_TIMER_CTRL, 32'h05);
		for (int p = 11; p >= 0; p--)
		begin
			fire(12'h1 << p);
			check("index", {28'h0, int_index}, {28'h0, p[3:0]});
			check("vector", {16'h0, int_vector}, {16'h0, MIP_VECTOR_TABLE[p]});
			rd_chk("vector reg", MIP_OFS_VECTOR, {1'b1, 11'h0, p[3:0], MIP_VECTOR_TABLE[p]});
		end
		rd_chk("timer ctrl", MIP_OFS_TIMER_CTRL, 32'hAF);
		rd_chk("serial ctrl", MIP_OFS_SERIAL_CTRL, 32'h02);
		rd_chk("timer2 ctrl", MIP_OFS_TIMER2_CTRL, 32'h80);
		rd_chk("power flag", MIP_OFS_PWR_FLAG, 32'h40);
		rd_chk("energy low", MIP_OFS_ESTAT_LOW, 32'h80);
		apb(1'b1, MIP_OFS_PWR_FLAG, 32'h0);
		idle(3);
		check("after power clear", {28'h0, int_index}, 32'h1);
		ack_enable <= 1'b1;
		idle(12);
		check("dsp held", {28'h0, taken_index}, 32'h2);
		apb(1'b1, MIP_OFS_ESTAT_LOW, 32'h0);
		idle(60);
		check("serial held", {28'h0, taken_index}, 32'hA);
		rd_chk("pins cleared", MIP_OFS_TIMER_CTRL, 32'h05);
		apb(1'b1, MIP_OFS_SERIAL_CTRL, 32'h0);
		idle(10);
		check("timer2 taken", {28'h0, taken_index}, 32'hB);
		apb(1'b1, MIP_OFS_TIMER2_CTRL, 32'h0);
		idle(4);
		ack_enable <= 1'b0;
		check("none valid", {31'h0, int_valid}, 32'h0);
		apb(1'b1, MIP_OFS_IMASK, 32'h1);
		idle(1);
		check("irq ack", {31'h0, irq}, 32'h1);
		apb(1'b1, MIP_OFS_ISTAT, 32'h1);
		idle(1);
		check("irq clear", {31'h0, irq}, 32'h0);
		$display("test order done");
	endtask
	task automatic t_level();
		apb(1'b1, MIP_OFS_LEVEL, 32'h800);
		fire(12'h801);
		check("high level", {28'h0, int_index}, 32'hB);
		apb(1'b1, MIP_OFS_LEVEL, 32'h0);
		idle(2);
		check("same level", {28'h0, int_index}, 32'h0);
		apb(1'b1, MIP_OFS_ENABLE, 32'hFFE);
		idle(2);
		check("disabled", {28'h0, int_index}, 32'hB);
		apb(1'b1, MIP_OFS_PWR_FLAG, 32'h0);
		apb(1'b1, MIP_OFS_TIMER2_CTRL, 32'h0);
		@(posedge mclk);
		t2e <= 1'b1;
		rxd <= 1'b1;
		@(posedge mclk);
		t2e <= 1'b0;
		rxd <= 1'b0;
		idle(2);
		rd_chk("timer2 ext", MIP_OFS_TIMER2_CTRL, 32'h40);
		rd_chk("serial rx", MIP_OFS_SERIAL_CTRL, 32'h01);
		check("rx over timer2", {28'h0, int_index}, 32'hA);
		apb(1'b1, MIP_OFS_SERIAL_CTRL, 32'h0);
		apb(1'b1, MIP_OFS_TIMER2_CTRL, 32'h0);
		$display("test level done");
	endtask
	task automatic t_gate();
		apb(1'b1, MIP_OFS_PIN_CFG, 32'h30);
		apb(1'b1, MIP_OFS_IMASK, 32'h2);
		fire(12'h0A0);
		rd_chk("gates closed", MIP_OFS_TIMER_CTRL, 32'h05);
		rd_chk("blocked", MIP_OFS_ISTAT, 32'h2);
		check("irq blocked", {31'h0, irq}, 32'h1);
		apb(1'b1, MIP_OFS_ISTAT, 32'h2);
		idle(1);
		check("irq cleared", {31'h0, irq}, 32'h0);
		apb(1'b1, MIP_OFS_PIN_CFG, 32'h40);
		fire(12'h0A0);
		rd_chk("pin b only", MIP_OFS_TIMER_CTRL, 32'h0D);
		apb(1'b1, MIP_OFS_PIN_CFG, 32'h01);
		fire(12'h020);
		rd_chk("pin a open", MIP_OFS_TIMER_CTRL, 32'h0F);
		apb(1'b1, MIP_OFS_TIMER_CTRL, 32'h04);
		@(posedge mclk);
		pin_a <= 1'b0;
		idle(3);
		rd_chk("pin a low level", MIP_OFS_TIMER_CTRL, 32'h06);
		@(posedge mclk);
		pin_a <= 1'b1;
		idle(2);
		rd_chk("pin a released", MIP_OFS_TIMER_CTRL, 32'h04);
		$display("test gate done");
	endtask
	initial
	begin
		idle(6);
		rst_b <= 1'b1;
		t_reset();
		t_order();
		t_level();
		t_gate();
		print_verdict();
	end
endmodule
